//--- hdl/tw_pkg.sv
package tw_pkg;

	// ----------------------------------------------------------------
	// Bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	// Least serial clock low time; a bit is four quarters of half of it
	localparam int SCL_LOW_NS = 1200;
	localparam int QTR_CYC = ((SCL_LOW_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest self-timed programming cycle, used as the polling limit
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_CYC = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Device address word and array layout
	// ----------------------------------------------------------------
	localparam logic [3:0] FAMILY = 4'hA;
	localparam int PAGE_BYTES = 8;
	localparam int RECOV_CLOCKS = 9;
	localparam logic [3:0] REC_LAST_START = 4'(RECOV_CLOCKS + 1);
	localparam logic [3:0] REC_STOP = 4'(RECOV_CLOCKS + 2);

	typedef enum logic [1:0] {OP_WRITE, OP_RD_CUR, OP_RD_RAND, OP_RECOVER} tw_op_t;

	typedef struct packed {
		tw_op_t op;
		logic [2:0] chip_sel;
		logic [7:0] word_adr;
		logic [6:0] len_m1;
	} tw_cmd_t;

	typedef enum logic [1:0] {BIT_START, BIT_STOP, BIT_WR, BIT_RD} tw_bit_t;

endpackage

//--- hdl/tw_bit_eng.sv
`timescale 1ns/100ps
module tw_bit_eng #(
	parameter int QTR = tw_pkg::QTR_CYC
)(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic go,
	input wire tw_pkg::tw_bit_t cmd,
	input wire logic wd,
	output logic done,
	output logic rd,
	output logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	import tw_pkg::*;

	localparam int CW = $clog2(QTR + 1);

	logic [CW-1:0] cnt_q;
	logic [1:0] ph_q;
	logic busy_q;
	tw_bit_t cmd_q;
	logic wd_q;
	logic scl_q;
	logic sda_oe_q;
	logic sda_o_q;
	logic done_q;
	logic rd_q;
	logic [1:0] sync_q;

	wire tick = busy_q && (cnt_q == '0);
	wire accept = go && !busy_q;
	wire [1:0] ph_nx = ph_q + 2'h1;
	// Data level for phase 1, while the clock is low (1 = released)
	wire rel1 = (cmd_q == BIT_START) || (cmd_q == BIT_RD) || ((cmd_q == BIT_WR) && wd_q);

	assign done = done_q;
	assign rd = rd_q;
	assign scl = scl_q;
	assign sda_o = sda_o_q;
	assign sda_oe = sda_oe_q;

	// ----------------------------------------------------------------
	// Quarter sequencer: clock low, data set, clock high, hold or edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			busy_q <= 1'b0;
			ph_q <= 2'h0;
			cnt_q <= '0;
			cmd_q <= BIT_RD;
			wd_q <= 1'b1;
			scl_q <= 1'b1;
			sda_oe_q <= 1'b0;
			sda_o_q <= 1'b0;
			done_q <= 1'b0;
			rd_q <= 1'b1;
			sync_q <= 2'h3;
		end
		else
		begin
			sync_q <= {sync_q[0], sda_i};
			done_q <= 1'b0;
			sda_o_q <= 1'b0;
			if (accept)
			begin
				busy_q <= 1'b1;
				ph_q <= 2'h0;
				cnt_q <= CW'(QTR - 1);
				cmd_q <= cmd;
				wd_q <= wd;
				scl_q <= 1'b0;
			end
			else if (tick && (ph_q == 2'h3))
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
				rd_q <= sync_q[1];
			end
			else if (tick)
			begin
				ph_q <= ph_nx;
				cnt_q <= CW'(QTR - 1);
				if (ph_nx == 2'h1)
					sda_oe_q <= !rel1; // [R3]
				if (ph_nx == 2'h2)
					scl_q <= 1'b1;
				if ((ph_nx == 2'h3) && (cmd_q == BIT_START))
					sda_oe_q <= 1'b1; // [R1]
				if ((ph_nx == 2'h3) && (cmd_q == BIT_STOP))
					sda_oe_q <= 1'b0; // [R2]
			end
			else if (busy_q)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [15:0] dur_q;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			dur_q <= 16'h0000;
		else if (busy_q)
			dur_q <= dur_q + 16'h0001;
		else
			dur_q <= 16'h0000;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_start_edge;
		$rose(sda_oe_q) && scl_q |-> (cmd_q == BIT_START) && (ph_q == 2'h3);
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("data fell with clock high outside a start"); // [R1]

	property p_stop_edge;
		$fell(sda_oe_q) && scl_q |-> (cmd_q == BIT_STOP) && (ph_q == 2'h3);
	endproperty
	a_stop_edge: assert property (p_stop_edge) else $error("data rose with clock high outside a stop"); // [R2]

	property p_data_low;
		$changed(sda_oe_q) |-> !scl_q || (((cmd_q == BIT_START) || (cmd_q == BIT_STOP)) && $past(scl_q));
	endproperty
	a_data_low: assert property (p_data_low) else $error("data changed while clock high"); // [R3]

	property p_bit_len;
		done_q |-> (dur_q == 16'(4 * QTR)) && scl_q;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit slot length wrong"); // [R3]

endmodule

//--- hdl/tw_host.sv
`timescale 1ns/100ps
// Protocol rules cited by the [Rn] tags
// [R1] Start: data falls while clock high
// [R2] Stop: data rises while clock high
// [R3] Data changes only while clock low
// [R4] Device acknowledges each byte on ninth clock
// [R5] Recovery: start, nine clocks, start, stop
// [R6] Device address opens with family pattern
// [R7] Device compares three chip-select bits
// [R8] Eighth address bit selects read or write
// [R9] Device acks on match, else standby
// [R10] Byte write: address, word, data, stop
// [R11] Device silent while programming runs
// [R12] Page write: up to eight bytes
// [R13] Write address wraps within page
// [R14] Poll device address until acknowledged
// [R15] Device keeps address counter plus one
// [R16] Read counter wraps over whole array
// [R17] Current read: no ack, then stop
// [R18] Random read: dummy write, repeated start
// [R19] Sequential read: ack for more bytes
// [R20] Device enters standby after stop
// [R21] Protect input blocks all array writes
// [R22] Array is sixteen pages of eight
// [R23] Device ignores word address top bit
// [R24] Protected writes acknowledged, not programmed
module tw_host #(
	parameter int POLL_CYC = tw_pkg::PROG_CYC,
	parameter int QTR = tw_pkg::QTR_CYC
)(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire tw_pkg::tw_cmd_t cmd,
	output logic cmd_ready,
	input wire logic [7:0] wdata,
	input wire logic wdata_valid,
	output logic wdata_take,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic done,
	output logic err,
	output logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	import tw_pkg::*;

	localparam int PW = $clog2(POLL_CYC + 1);

	typedef enum logic [3:0] {ST_IDLE, ST_START, ST_TXBIT, ST_TXACK, ST_WGET, ST_RXBIT, ST_RXACK, ST_STOP,
		ST_REC} tw_state_t;
	typedef enum logic [2:0] {PH_DEV, PH_WADR, PH_WDATA, PH_DEVR, PH_RDATA} tw_phase_t;

	tw_state_t st_q, st_d;
	tw_phase_t ph_q, ph_d;
	tw_cmd_t cmd_q, cmd_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bit_n_q, bit_n_d;
	logic [6:0] left_q, left_d;
	logic wait_q, wait_d;
	logic go_q, go_d;
	tw_bit_t bcmd_q, bcmd_d;
	logic bwd_q, bwd_d;
	logic retry_q, retry_d;
	logic pollon_q, pollon_d;
	logic [PW-1:0] poll_q, poll_d;
	logic ready_q, ready_d;
	logic take_q, take_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic done_q, done_d;
	logic err_q, err_d;
	logic bit_done;
	logic bit_rd;

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire take_cmd = cmd_valid && ready_q;
	wire [6:0] len_in = ((cmd.op == OP_WRITE) && (cmd.len_m1 > 7'(PAGE_BYTES - 1))) ?
		7'(PAGE_BYTES - 1) : cmd.len_m1; // [R12]
	wire rw_bit = (ph_q == PH_DEVR) || (cmd_q.op == OP_RD_CUR); // [R8]
	wire [7:0] dev_byte = {FAMILY, cmd_q.chip_sel, rw_bit}; // [R6]
	wire rec_start = (bit_n_q == 4'h0) || (bit_n_q == REC_LAST_START);
	wire tw_bit_t rec_cmd = rec_start ? BIT_START : ((bit_n_q == REC_STOP) ? BIT_STOP : BIT_RD); // [R5]
	wire tw_bit_t want_cmd = (st_q == ST_START) ? BIT_START :
		(st_q == ST_STOP) ? BIT_STOP :
		((st_q == ST_TXBIT) || (st_q == ST_RXACK)) ? BIT_WR :
		(st_q == ST_REC) ? rec_cmd : BIT_RD;
	// Ack every read byte but the last, which gets a released line
	wire want_wd = (st_q == ST_TXBIT) ? sh_q[7] : (left_q == 7'h00); // [R19]
	wire need_bit = (st_q != ST_IDLE) && (st_q != ST_WGET);
	wire can_poll = (ph_q == PH_DEV) && (poll_q < PW'(POLL_CYC));

	assign cmd_ready = ready_q;
	assign wdata_take = take_q;
	assign rdata = rdata_q;
	assign rdata_valid = rvalid_q;
	assign done = done_q;
	assign err = err_q;

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		ph_d = ph_q;
		cmd_d = cmd_q;
		sh_d = sh_q;
		bit_n_d = bit_n_q;
		left_d = left_q;
		wait_d = wait_q;
		go_d = 1'b0;
		bcmd_d = bcmd_q;
		bwd_d = bwd_q;
		retry_d = retry_q;
		pollon_d = pollon_q;
		// Polling gives up once the longest programming time has passed
		poll_d = (pollon_q && (poll_q != PW'(POLL_CYC))) ? poll_q + 1'b1 : poll_q;
		take_d = 1'b0;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		done_d = 1'b0;
		err_d = err_q;
		if (need_bit && !wait_q)
		begin
			go_d = 1'b1;
			wait_d = 1'b1;
			bcmd_d = want_cmd;
			bwd_d = want_wd;
		end
		else if (bit_done)
			wait_d = 1'b0;
		case (st_q)
			ST_IDLE:
			begin
				if (take_cmd)
				begin
					cmd_d = cmd;
					left_d = len_in;
					err_d = 1'b0;
					poll_d = '0;
					pollon_d = 1'b0;
					retry_d = 1'b0;
					bit_n_d = 4'h0;
					ph_d = PH_DEV;
					st_d = (cmd.op == OP_RECOVER) ? ST_REC : ST_START;
				end
			end
			ST_START:
			begin
				if (bit_done)
				begin
					sh_d = dev_byte;
					bit_n_d = 4'h0;
					st_d = ST_TXBIT;
				end
			end
			ST_TXBIT:
			begin
				if (bit_done)
				begin
					sh_d = {sh_q[6:0], 1'b0};
					bit_n_d = bit_n_q + 4'h1;
					if (bit_n_q == 4'h7)
						st_d = ST_TXACK;
				end
			end
			ST_TXACK:
			begin
				if (bit_done && bit_rd && can_poll)
				begin
					pollon_d = 1'b1;
					retry_d = 1'b1; // [R14]
					st_d = ST_STOP;
				end
				else if (bit_done && bit_rd)
				begin
					err_d = 1'b1;
					st_d = ST_STOP;
				end
				else if (bit_done)
				begin
					bit_n_d = 4'h0;
					case (ph_q)
						PH_DEV:
						begin
							pollon_d = 1'b0;
							if (cmd_q.op == OP_RD_CUR)
							begin
								ph_d = PH_RDATA;
								st_d = ST_RXBIT; // [R17]
							end
							else
							begin
								ph_d = PH_WADR;
								sh_d = cmd_q.word_adr;
								st_d = ST_TXBIT; // [R10]
							end
						end
						PH_WADR:
						begin
							if (cmd_q.op == OP_RD_RAND)
							begin
								ph_d = PH_DEVR;
								st_d = ST_START; // [R18]
							end
							else
							begin
								ph_d = PH_WDATA;
								st_d = ST_WGET;
							end
						end
						PH_WDATA:
						begin
							if (left_q == 7'h00)
								st_d = ST_STOP; // [R10]
							else
							begin
								left_d = left_q - 7'h01;
								st_d = ST_WGET; // [R12]
							end
						end
						PH_DEVR:
						begin
							ph_d = PH_RDATA;
							st_d = ST_RXBIT;
						end
						default:
							st_d = ST_STOP;
					endcase
				end
			end
			ST_WGET:
			begin
				// The clock rests high until the user offers a byte
				if (wdata_valid)
				begin
					take_d = 1'b1;
					sh_d = wdata;
					bit_n_d = 4'h0;
					st_d = ST_TXBIT;
				end
			end
			ST_RXBIT:
			begin
				if (bit_done)
				begin
					sh_d = {sh_q[6:0], bit_rd};
					bit_n_d = bit_n_q + 4'h1;
					if (bit_n_q == 4'h7)
					begin
						rdata_d = {sh_q[6:0], bit_rd};
						rvalid_d = 1'b1;
						st_d = ST_RXACK;
					end
				end
			end
			ST_RXACK:
			begin
				if (bit_done && (left_q == 7'h00))
					st_d = ST_STOP; // [R17]
				else if (bit_done)
				begin
					left_d = left_q - 7'h01;
					bit_n_d = 4'h0;
					st_d = ST_RXBIT; // [R19]
				end
			end
			ST_STOP:
			begin
				if (bit_done && retry_q)
				begin
					retry_d = 1'b0;
					st_d = ST_START; // [R14]
				end
				else if (bit_done)
				begin
					done_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_REC:
			begin
				if (bit_done && (bit_n_q == REC_STOP))
				begin
					done_d = 1'b1;
					st_d = ST_IDLE;
				end
				else if (bit_done)
					bit_n_d = bit_n_q + 4'h1; // [R5]
			end
			default:
				st_d = ST_IDLE;
		endcase
		ready_d = (st_d == ST_IDLE) && !take_cmd;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			st_q <= ST_IDLE;
			ph_q <= PH_DEV;
			cmd_q <= '0;
			sh_q <= 8'h00;
			bit_n_q <= 4'h0;
			left_q <= 7'h00;
			wait_q <= 1'b0;
			go_q <= 1'b0;
			bcmd_q <= BIT_RD;
			bwd_q <= 1'b1;
			retry_q <= 1'b0;
			pollon_q <= 1'b0;
			poll_q <= '0;
			ready_q <= 1'b0;
			take_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			ph_q <= ph_d;
			cmd_q <= cmd_d;
			sh_q <= sh_d;
			bit_n_q <= bit_n_d;
			left_q <= left_d;
			wait_q <= wait_d;
			go_q <= go_d;
			bcmd_q <= bcmd_d;
			bwd_q <= bwd_d;
			retry_q <= retry_d;
			pollon_q <= pollon_d;
			poll_q <= poll_d;
			ready_q <= ready_d;
			take_q <= take_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin engine
	// ----------------------------------------------------------------
	tw_bit_eng #(
		.QTR(QTR)
	) u_eng (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.go(go_q),
		.cmd(bcmd_q),
		.wd(bwd_q),
		.done(bit_done),
		.rd(bit_rd),
		.scl(scl),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [3:0] wcnt_q;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst || take_cmd)
			wcnt_q <= 4'h0;
		else if (take_q)
			wcnt_q <= wcnt_q + 4'h1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_dev_word;
		(st_q == ST_START) && bit_done |=> (sh_q[7:4] == FAMILY) && (sh_q[3:1] == cmd_q.chip_sel);
	endproperty
	a_dev_word: assert property (p_dev_word) else $error("device address word malformed"); // [R6]

	property p_rw_sel;
		(st_q == ST_START) && bit_done |=>
			sh_q[0] == ((cmd_q.op == OP_RD_CUR) || ((cmd_q.op == OP_RD_RAND) && (ph_q == PH_DEVR)));
	endproperty
	a_rw_sel: assert property (p_rw_sel) else $error("direction bit wrong"); // [R8]

	property p_page;
		wcnt_q <= 4'(PAGE_BYTES);
	endproperty
	a_page: assert property (p_page) else $error("more than one page of data sent"); // [R12]

	property p_last_nack;
		go_q && (st_q == ST_RXACK) |-> (bwd_q == (left_q == 7'h00)) ##1 wait_q[*3];
	endproperty
	a_last_nack: assert property (p_last_nack) else $error("read ack level wrong"); // [R19]

	property p_read_end;
		(st_q == ST_RXACK) && bit_done && (left_q == 7'h00) |=> (st_q == ST_STOP) ##1 go_q && (bcmd_q == BIT_STOP);
	endproperty
	a_read_end: assert property (p_read_end) else $error("no stop after final read byte"); // [R17]

	property p_rand_only;
		(ph_q == PH_DEVR) && go_q && (bcmd_q == BIT_START) |-> (cmd_q.op == OP_RD_RAND);
	endproperty
	a_rand_only: assert property (p_rand_only) else $error("repeated start outside random read"); // [R18]

	property p_rec_clocks;
		go_q && (st_q == ST_REC) && (bcmd_q == BIT_RD) |-> (bit_n_q >= 4'h1) && (bit_n_q <= 4'(RECOV_CLOCKS));
	endproperty
	a_rec_clocks: assert property (p_rec_clocks) else $error("recovery clock count wrong"); // [R5]

	property p_poll_bound;
		(st_q == ST_STOP) && bit_done && retry_q |-> poll_q <= PW'(POLL_CYC) ##1 (st_q == ST_START);
	endproperty
	a_poll_bound: assert property (p_poll_bound) else $error("poll retry beyond limit"); // [R14]

	property p_write_stop;
		(st_q == ST_TXACK) && bit_done && !bit_rd && (ph_q == PH_WDATA) && (left_q == 7'h00) |=> st_q == ST_STOP;
	endproperty
	a_write_stop: assert property (p_write_stop) else $error("write not closed by stop"); // [R10]

endmodule

//--- tb/tw_eeprom_model.sv
`timescale 1ns/100ps
module tw_eeprom_model #(
	parameter logic [2:0] CS = 3'h5,
	parameter int PROG_NS = 20000
)(
	input wire logic scl,
	input wire logic sda,
	input wire logic wp,
	output logic pull
);
	logic [7:0] mem [128];
	logic [7:0] sh, tx;
	logic [6:0] cnt;
	logic rd, busy;
	int ph, bitn;
	logic [6:0] pa [$];
	logic [7:0] pd [$];
	initial
	begin
		pull = 0; ph = 0; bitn = 0; busy = 0; cnt = 0; rd = 0;
		foreach (mem[i]) mem[i] = 8'(i * 3);
	end
	// ------------------------------------------------
	// Framing
	// ------------------------------------------------
	always @(negedge sda)
		if (scl)
		begin
			ph = busy ? 0 : 1;
			bitn = 0;
			pull = 0;
			pa.delete();
			pd.delete();
		end
	always @(posedge sda)
		if (scl)
		begin
			// Page contents land only after the stop
			if (ph == 3 && pd.size() > 0 && !wp)
			begin
				foreach (pd[i]) mem[pa[i]] = pd[i];
				busy = 1;
				fork
				begin
					#(PROG_NS);
					busy = 0;
				end
				join_none
			end
			ph = 0;
		end
	// ------------------------------------------------
	// Bit slots
	// ------------------------------------------------
	always @(posedge scl)
		if (ph != 0)
		begin
			if (bitn < 8) sh = {sh[6:0], sda};
			else if (ph == 4 && sda) ph = 5;
			bitn++;
		end
	always @(negedge scl)
		if (ph != 0)
		begin
			pull = 0;
			if (bitn == 8)
			begin
				case (ph)
					1: if (sh[7:4] == 4'hA && sh[3:1] == CS) {pull, rd} = {1'b1, sh[0]}; else ph = 0;
					2: {cnt, pull} = {sh[6:0], 1'b1};
					3:
					begin
						pa.push_back(cnt);
						pd.push_back(sh);
						cnt[2:0] = cnt[2:0] + 3'h1;
						pull = 1;
					end
					default: pull = 0;
				endcase
			end
			else if (bitn == 9)
			begin
				bitn = 0;
				if ((ph == 1 && rd) || ph == 4)
				begin
					ph = 4;
					tx = mem[cnt];
					cnt = cnt + 7'h01;
				end
				else if (ph < 3) ph = ph + 1;
			end
			if (ph == 4 && bitn < 8) pull = !tx[7 - bitn];
		end
endmodule

//--- tb/tb_tw_host.sv
`timescale 1ns/100ps
module tb_tw_host;
	import tw_pkg::*;
	typedef struct {
		tw_op_t op;
		logic [2:0] cs;
		logic [7:0] adr;
		logic [6:0] len;
		logic wp;
		logic err;
	} tw_row_t;
	logic clk_sys = 0, nrst = 0, cmd_valid = 0, wdata_valid = 0, wp = 0;
	tw_cmd_t cmd = '0;
	logic cmd_ready, wdata_take, rdata_valid, done, err, scl, sda_o, sda_oe, pull, sda;
	logic [7:0] rdata, wdata, wbase = 0;
	logic [7:0] shadow [128];
	logic [7:0] got [$];
	logic [6:0] ctr = 0;
	int widx = 0, err_count = 0, samples_checked = 0;
	tw_row_t rows [14] = '{
		'{OP_WRITE, 3'h5, 8'h83, 7'h02, 1'b0, 1'b0},
		'{OP_RD_RAND, 3'h5, 8'h03, 7'h03, 1'b0, 1'b0},
		'{OP_RD_CUR, 3'h5, 8'h00, 7'h00, 1'b0, 1'b0},
		'{OP_WRITE, 3'h5, 8'h16, 7'h07, 1'b0, 1'b0},
		'{OP_RD_RAND, 3'h5, 8'h10, 7'h07, 1'b0, 1'b0},
		'{OP_RD_RAND, 3'h5, 8'h7F, 7'h02, 1'b0, 1'b0},
		'{OP_WRITE, 3'h5, 8'h20, 7'h01, 1'b1, 1'b0},
		'{OP_RD_RAND, 3'h5, 8'h20, 7'h01, 1'b0, 1'b0},
		'{OP_RECOVER, 3'h5, 8'h00, 7'h00, 1'b0, 1'b0},
		'{OP_RD_CUR, 3'h5, 8'h00, 7'h00, 1'b0, 1'b0},
		'{OP_WRITE, 3'h3, 8'h00, 7'h00, 1'b0, 1'b1},
		'{OP_RD_RAND, 3'h4, 8'h00, 7'h00, 1'b0, 1'b1},
		'{OP_RD_CUR, 3'h5, 8'h00, 7'h00, 1'b0, 1'b0},
		'{OP_WRITE, 3'h5, 8'h41, 7'h0A, 1'b0, 1'b0}
	};
	// Open-drain data line with a pull-up
	assign sda = (sda_oe || pull) ? 1'b0 : 1'b1;
	assign wdata = wbase + 8'(widx);
	tw_host #(.POLL_CYC(12000), .QTR(4)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .wdata(wdata), .wdata_valid(wdata_valid), .wdata_take(wdata_take),
		.rdata(rdata), .rdata_valid(rdata_valid), .done(done), .err(err), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe));
	tw_eeprom_model #(.CS(3'h5), .PROG_NS(20000)) dev_u (.scl(scl), .sda(sda), .wp(wp), .pull(pull));
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (rdata_valid === 1'b1) got.push_back(rdata);
		#1;
		if (wdata_take === 1'b1) widx++;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ------------------------------------------------
	// Command issue and completion
	// ------------------------------------------------
	task automatic issue(input tw_row_t r);
		int n;
		@(posedge clk_sys);
		#1;
		got.delete();
		widx = 0;
		wbase = 8'h5A + r.adr;
		wp = r.wp;
		wdata_valid = (r.op == OP_WRITE);
		cmd = '{r.op, r.cs, r.adr, r.len};
		cmd_valid = 1;
		n = 0;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 100);
		#1;
		if (n >= 100) err_count++;
		cmd_valid = 0;
	endtask
	task automatic run(input tw_row_t r);
		int n;
		int nb;
		issue(r);
		n = 0;
		do @(posedge clk_sys); while (done !== 1'b1 && ++n < 20000);
		#1;
		if (n >= 20000) err_count++;
		if (r.op != OP_RECOVER) check(8'(err), 8'(r.err));
		if (r.err) return;
		if (r.op == OP_WRITE)
		begin
			// Longer write requests are cut to one page by the host
			nb = (r.len > 7'(PAGE_BYTES - 1)) ? PAGE_BYTES : int'(r.len) + 1;
			for (int k = 0; k < nb; k++)
				if (!r.wp) shadow[{r.adr[6:3], 3'(r.adr[2:0] + k)}] = wbase + 8'(k);
			ctr = {r.adr[6:3], 3'(r.adr[2:0] + nb)};
			check(8'(widx), 8'(nb));
		end
		else if (r.op != OP_RECOVER)
		begin
			if (r.op == OP_RD_RAND) ctr = r.adr[6:0];
			check(8'(got.size()), 8'(r.len) + 8'h01);
			foreach (got[k])
			begin
				check(got[k], shadow[ctr]);
				ctr++;
			end
		end
	endtask
	initial
	begin
		#400000;
		err_count++;
		summarize();
	end
	initial
	begin
		foreach (shadow[i]) shadow[i] = 8'(i * 3);
		repeat (5) @(posedge clk_sys);
		#1;
		check({5'h00, sda_o, scl, sda_oe}, 8'h02);
		check(8'(cmd_ready), 8'h00);
		nrst = 1;
		@(posedge clk_sys);
		#1;
		check(8'(cmd_ready), 8'h01);
		foreach (rows[i]) run(rows[i]);
		// ------------------------------------------------
		// Reset in the middle of a device address
		// ------------------------------------------------
		issue(rows[0]);
		repeat (100) @(posedge clk_sys);
		#1;
		nrst = 0;
		repeat (3) @(posedge clk_sys);
		#1;
		check({5'h00, sda_o, scl, sda_oe}, 8'h02);
		nrst = 1;
		run(rows[2]);
		summarize();
	end
endmodule
